// ===== sdl_defs.svh
// Constants for the single-wire debug serial link.
`ifndef SDL_DEFS_SVH
`define SDL_DEFS_SVH
`define SDL_CLK_PERIOD_NS 10
`define SDL_MIN_DIV 4
`define SDL_REC_DIV 8
`define SDL_MAX_DIV 512
`define SDL_BREAK_BITS 9
`define SDL_CHAR_BITS 10
`define SDL_DATA_BITS 8
`define SDL_ERR_BREAK_CHARS 4
`define SDL_ERR_BREAK_BITS (`SDL_ERR_BREAK_CHARS * `SDL_CHAR_BITS)
`define SDL_SYNC_LOW_BITS 8
`define SDL_SYNC_SHIFT 3
`define SDL_SYNC_CHAR 8'h80
`define SDL_CMD_EXEC 8'h12
`endif

// ===== sdl_pkg.sv
// Types and helpers for the single-wire debug serial link.
package sdl_pkg;
  typedef logic [7:0] sdl_byte_t;
  typedef logic [9:0] sdl_period_t;
  typedef logic [12:0] sdl_count_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX_START, ST_RX_DATA, ST_RX_STOP, ST_TX_BIT, ST_ERR_BREAK
  } sdl_state_t;
  typedef enum logic [1:0] {
    AB_WAIT_HIGH, AB_WAIT_LOW, AB_COUNT, AB_LOCKED
  } sdl_ab_state_t;
  // Scales a bit period by a number of bit times.
  function automatic sdl_count_t sdl_scale(input sdl_period_t per, input logic [3:0] bits);
    sdl_count_t prod;
    prod = 13'(per) * 13'(bits);
    return prod;
  endfunction
endpackage

// ===== sdl_autobaud.sv
// Auto-baud detector that measures the bit period from the sync character.
`timescale 1ns/1ps
`include "sdl_defs.svh"
module sdl_autobaud (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Synchronised wire level and restart request.
  input wire logic pinLevel,
  input wire logic abClear,
  // Measured result.
  output sdl_pkg::sdl_period_t bitPeriod,
  output logic baudLocked
);
  import sdl_pkg::*;
  sdl_ab_state_t abState_reg, abState_next;
  sdl_count_t lowCnt_reg, lowCnt_next;
  sdl_period_t period_reg, period_next;
  wire sdl_period_t measured = lowCnt_reg[12:`SDL_SYNC_SHIFT];
  wire measOk = (measured >= 10'(`SDL_MIN_DIV)) && // [RULE_02]
    (measured <= 10'(`SDL_MAX_DIV)); // [RULE_01]
  wire lowSat = lowCnt_reg == 13'h1fff;

  always_comb begin
    abState_next = abState_reg;
    lowCnt_next = lowCnt_reg;
    period_next = period_reg;
    if (abClear) begin
      abState_next = AB_WAIT_HIGH;
    end else begin
      unique case (abState_reg)
        AB_WAIT_HIGH: if (pinLevel) abState_next = AB_WAIT_LOW;
        AB_WAIT_LOW: begin
          lowCnt_next = 13'h0001;
          if (!pinLevel) abState_next = AB_COUNT;
        end
        AB_COUNT: begin
          if (!pinLevel) begin
            if (!lowSat) lowCnt_next = lowCnt_reg + 13'h0001; // [RULE_13]
          end else if (measOk) begin
            period_next = measured; // [RULE_13]
            abState_next = AB_LOCKED;
          end else begin
            abState_next = AB_WAIT_LOW;
          end
        end
        AB_LOCKED: abState_next = AB_LOCKED;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      abState_reg <= AB_WAIT_HIGH;
      lowCnt_reg <= 13'h0000;
      period_reg <= 10'(`SDL_REC_DIV);
    end else begin
      abState_reg <= abState_next;
      lowCnt_reg <= lowCnt_next;
      period_reg <= period_next;
    end
  end

  assign bitPeriod = period_reg;
  assign baudLocked = abState_reg == AB_LOCKED;

  period_range_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_01]
    baudLocked |-> (bitPeriod >= 10'(`SDL_MIN_DIV)) && (bitPeriod <= 10'(`SDL_MAX_DIV)))
    else $error("Locked bit period out of range.");
  baud_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_03]
    abClear |=> !baudLocked [*2])
    else $error("Auto-baud stayed locked after a clear.");
endmodule // sdl_autobaud

// ===== sdl_link_top.sv
// Serial front end of the on-chip debug unit on one open-drain wire.
// Behaviour
// [RULE_01] Auto-baud runs on system clock, bit periods up to 512 clocks.
// [RULE_02] Link rate at most clock/8 advised; clock/4 is the hard floor.
// [RULE_03] Nine or more low bit times is a break; auto-baud restarts.
// [RULE_04] Host sends 80H after a break so the period can be measured.
// [RULE_05] Break, low stop bit and transmit collision are flagged as errors.
// [RULE_06] Any error aborts the command, returns a four-character break, resets baud.
// [RULE_07] Host sends a break on first connection and on error recovery.
// [RULE_08] A break leaves the halt state bit untouched.
// [RULE_09] Debug unit stays in reset until the wire returns high after a break.
// [RULE_10] Both ends drive open-drain; the wire is a wired-AND.
// [RULE_11] Execute-opcode outside halt or under protection discards one byte.
// [RULE_12] Halt state bit stops core fetching; clearing it resumes execution.
// [RULE_13] Bit period comes from counting clocks over the 80H low interval.
`timescale 1ns/1ps
`include "sdl_defs.svh"
module sdl_link_top (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Debug wire pin.
  input wire logic debugWirePinIn,
  output logic debugWirePinOut,
  output logic debugWirePinOe,
  // Received bytes toward the command engine.
  output sdl_pkg::sdl_byte_t rxData,
  output logic rxValid,
  input wire logic cmdExpect,
  // Bytes to send to the host.
  input wire sdl_pkg::sdl_byte_t txData,
  input wire logic txValid,
  output logic txReady,
  // Halt control.
  input wire logic haltSetReq,
  input wire logic haltClrReq,
  input wire logic readProtect,
  output logic haltStateBit,
  output logic coreFetchEn,
  // Link status.
  output logic onchipDebugReset,
  output logic cmdAbort,
  output logic errBreak,
  output logic errFrame,
  output logic errCollision,
  output logic baudLocked,
  output sdl_pkg::sdl_period_t bitPeriod
);
  import sdl_pkg::*;
  logic pinMeta_reg, pinSync_reg;
  sdl_state_t state_reg, state_next;
  sdl_period_t perCnt_reg, perCnt_next;
  logic [5:0] bitCnt_reg, bitCnt_next;
  logic [9:0] shift_reg, shift_next;
  sdl_count_t lowCnt_reg;
  logic discard_reg, breakHeld_reg, halt_reg;
  sdl_byte_t rxData_reg;
  logic rxValid_reg, errBreak_reg, errFrame_reg, errCol_reg, abort_reg;
  logic abClear;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_reg <= 1'b1;
      pinSync_reg <= 1'b1;
    end else begin
      pinMeta_reg <= debugWirePinIn;
      pinSync_reg <= pinMeta_reg;
    end
  end
  wire pinLevel = pinSync_reg;

  sdl_autobaud u_autobaud (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinLevel(pinLevel),
    .abClear(abClear),
    .bitPeriod(bitPeriod),
    .baudLocked(baudLocked)
  );

  // Timing and decode terms.
  wire inErr = state_reg == ST_ERR_BREAK;
  wire inTx = state_reg == ST_TX_BIT;
  wire driveLow = inErr | (inTx & ~shift_reg[0]);
  wire perDone = perCnt_reg == 10'h000;
  wire sdl_period_t halfPer = {1'b0, bitPeriod[9:1]};
  wire sdl_period_t perLoad = bitPeriod - 10'h001;
  wire sdl_count_t breakLimit = sdl_scale(bitPeriod, 4'(`SDL_BREAK_BITS));
  wire brkDet = baudLocked & (lowCnt_reg == breakLimit) & ~inErr; // [RULE_03]
  wire frmDet = (state_reg == ST_RX_STOP) & perDone & ~pinLevel; // [RULE_05]
  wire colDet = inTx & shift_reg[0] & (perCnt_reg == halfPer) & ~pinLevel; // [RULE_05]
  wire errAny = brkDet | frmDet | colDet;
  wire byteDone = (state_reg == ST_RX_STOP) & perDone & pinLevel;
  wire sdl_byte_t rxByte = shift_reg[9:2];
  wire isExec = rxByte == `SDL_CMD_EXEC;
  wire execRefused = ~halt_reg | readProtect;
  wire linkFree = (state_reg == ST_IDLE) & baudLocked & ~breakHeld_reg;
  wire rxStart = linkFree & ~pinLevel;
  wire txStart = linkFree & pinLevel & txValid;
  wire errBrkDone = inErr & perDone & (bitCnt_reg == 6'(`SDL_ERR_BREAK_BITS - 1));
  assign abClear = errBrkDone; // [RULE_06]

  always_comb begin
    state_next = state_reg;
    perCnt_next = perDone ? perLoad : perCnt_reg - 10'h001;
    bitCnt_next = bitCnt_reg;
    shift_next = shift_reg;
    if (errAny) begin
      state_next = ST_ERR_BREAK; // [RULE_06]
      perCnt_next = perLoad;
      bitCnt_next = 6'h00;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          perCnt_next = halfPer;
          bitCnt_next = 6'h00;
          if (rxStart) begin
            state_next = ST_RX_START;
          end else if (txStart) begin
            state_next = ST_TX_BIT;
            perCnt_next = perLoad;
            shift_next = {1'b1, txData, 1'b0};
          end
        end
        ST_RX_START: begin
          if (perDone) state_next = pinLevel ? ST_IDLE : ST_RX_DATA;
        end
        ST_RX_DATA: begin
          if (perDone) begin
            shift_next = {pinLevel, shift_reg[9:1]};
            bitCnt_next = bitCnt_reg + 6'h01;
            if (bitCnt_reg == 6'(`SDL_DATA_BITS - 1)) state_next = ST_RX_STOP;
          end
        end
        ST_RX_STOP: begin
          if (perDone) state_next = ST_IDLE;
        end
        ST_TX_BIT: begin
          if (perDone) begin
            shift_next = {1'b1, shift_reg[9:1]};
            bitCnt_next = bitCnt_reg + 6'h01;
            if (bitCnt_reg == 6'(`SDL_CHAR_BITS - 1)) state_next = ST_IDLE;
          end
        end
        ST_ERR_BREAK: begin
          if (perDone) begin
            bitCnt_next = bitCnt_reg + 6'h01;
            if (errBrkDone) state_next = ST_IDLE;
          end
        end
      endcase
    end
  end

  wire discardNext = byteDone & ~discard_reg & cmdExpect & isExec & execRefused;
  wire discardDone = (byteDone & discard_reg) | errAny;
  wire haltNext = haltSetReq | (halt_reg & ~(haltClrReq & ~readProtect));
  wire breakHeldNext = brkDet | (breakHeld_reg & ~(pinLevel & ~inErr));
  wire lowCount = ~pinLevel & ~driveLow;
  wire lowSat = lowCnt_reg == 13'h1fff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      perCnt_reg <= 10'h000;
      bitCnt_reg <= 6'h00;
      shift_reg <= 10'h3ff;
    end else begin
      state_reg <= state_next;
      perCnt_reg <= perCnt_next;
      bitCnt_reg <= bitCnt_next;
      shift_reg <= shift_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt_reg <= 13'h0000;
    end else if (!lowCount) begin
      lowCnt_reg <= 13'h0000;
    end else if (!lowSat) begin
      lowCnt_reg <= lowCnt_reg + 13'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      discard_reg <= 1'b0;
      breakHeld_reg <= 1'b0;
      halt_reg <= 1'b0;
    end else begin
      discard_reg <= discardNext | (discard_reg & ~discardDone); // [RULE_11]
      breakHeld_reg <= breakHeldNext; // [RULE_09]
      halt_reg <= haltNext; // [RULE_08]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxData_reg <= 8'h00;
      rxValid_reg <= 1'b0;
    end else begin
      rxValid_reg <= byteDone & ~discard_reg; // [RULE_11]
      if (byteDone) rxData_reg <= rxByte;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      errBreak_reg <= 1'b0;
      errFrame_reg <= 1'b0;
      errCol_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      errBreak_reg <= brkDet;
      errFrame_reg <= frmDet;
      errCol_reg <= colDet;
      abort_reg <= errAny; // [RULE_06]
    end
  end

  // Open-drain drive: the pin is only ever pulled low.
  assign debugWirePinOut = 1'b0; // [RULE_10]
  assign debugWirePinOe = driveLow; // [RULE_10]
  assign rxData = rxData_reg;
  assign rxValid = rxValid_reg;
  assign txReady = linkFree & pinLevel;
  assign haltStateBit = halt_reg;
  assign coreFetchEn = ~halt_reg; // [RULE_12]
  assign onchipDebugReset = breakHeld_reg;
  assign cmdAbort = abort_reg;
  assign errBreak = errBreak_reg;
  assign errFrame = errFrame_reg;
  assign errCollision = errCol_reg;

  break_response_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_03]
    brkDet |=> inErr && debugWirePinOe && errBreak && onchipDebugReset)
    else $error("Break not answered with a returned break.");
  frame_error_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_05]
    (state_reg == ST_RX_STOP && perDone && !pinLevel) |=> errFrame && cmdAbort && inErr)
    else $error("Low stop bit not flagged.");
  collision_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_05]
    (inTx && shift_reg[0] && perCnt_reg == halfPer && !pinLevel) |=> errCollision && inErr)
    else $error("Collision not flagged.");
  err_break_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_06]
    $rose(inErr) |-> debugWirePinOe [*8])
    else $error("Returned break shorter than expected.");
  err_break_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_06]
    errBrkDone |=> !baudLocked && !debugWirePinOe)
    else $error("Auto-baud not reset after returned break.");
  halt_kept_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_08]
    (!haltSetReq && !haltClrReq) |=> haltStateBit == $past(haltStateBit))
    else $error("Halt state bit changed without a request.");
  reset_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_09]
    (onchipDebugReset && !pinLevel) |=> onchipDebugReset)
    else $error("Debug reset released while wire low.");
  reset_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_09]
    (onchipDebugReset && pinLevel && !inErr && !brkDet) |=> !onchipDebugReset)
    else $error("Debug reset held after wire went high.");
  wire_and_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_10]
    debugWirePinOe [*3] |-> !pinLevel)
    else $error("Driven wire not seen low.");
  exec_discard_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_11]
    (byteDone && discard_reg) |=> !rxValid && !discard_reg)
    else $error("Discarded byte was delivered.");
  fetch_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_12]
    haltSetReq |=> !coreFetchEn)
    else $error("Core still fetching after halt.");
endmodule // sdl_link_top

// ===== sdl_host_model.sv
// Behavioural debug host on the shared open-drain debug wire.
`timescale 1ns/1ps
module sdl_host_model #(
  parameter int HP = 10
) (
  // Clock and wire level.
  input wire logic ref_clk,
  input wire logic wireLevel,
  // Host pull-down enable.
  output logic hostOe
);
  initial hostOe = 1'b0;
  // Pulls the wire low for n clocks; a break when n covers nine bits.
  task automatic hold_low(input int n);
    hostOe <= 1'b1;
    repeat (n) @(posedge ref_clk);
    hostOe <= 1'b0;
  endtask
  // Sends one 8N1 frame, LSB first, at HP clocks a bit.
  task automatic send_byte(input logic [7:0] b, input logic stopBit);
    logic [9:0] fr;
    fr = {stopBit, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      hostOe <= ~fr[i];
      repeat (HP) @(posedge ref_clk);
    end
    hostOe <= 1'b0;
  endtask
  // Samples one device frame in the middle of each bit.
  task automatic recv_byte(output logic [7:0] b, output logic stopBit, output bit lost);
    int t;
    t = 0;
    b = 8'h00;
    while (wireLevel !== 1'b0 && t < 200) begin
      @(posedge ref_clk);
      t++;
    end
    lost = (wireLevel !== 1'b0);
    repeat (HP / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (HP) @(posedge ref_clk);
      b[i] = wireLevel;
    end
    repeat (HP) @(posedge ref_clk);
    stopBit = wireLevel;
  endtask
endmodule // sdl_host_model

// ===== sdl_link_top_test.sv
// Self-checking bench for the single-wire debug serial link.
`timescale 1ns/1ps
`include "sdl_defs.svh"
module sdl_link_top_test;
  import sdl_pkg::*;
  localparam int P = 10;
  logic ref_clk, rst_n, cmdExpect, txValid, haltSetReq, haltClrReq, readProtect;
  logic pinOut, pinOe, rxValid, txReady, haltStateBit, coreFetchEn, onchipDebugReset;
  logic cmdAbort, errBreak, errFrame, errCollision, baudLocked, hostOe, wireLevel, sb;
  sdl_byte_t txData, rxData, lastRx, got;
  sdl_period_t bitPeriod;
  int failures, check_count, nRx, nFrame, nBreak, nColl, nAbort, nLock, nRel;
  int oeRun, lastRun, nOeEnd, b0, b1;
  bit wasLock, wasRst, lost;
  assign wireLevel = ~(hostOe | pinOe);
  sdl_link_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .debugWirePinIn(wireLevel),
    .debugWirePinOut(pinOut), .debugWirePinOe(pinOe), .rxData(rxData), .rxValid(rxValid),
    .cmdExpect(cmdExpect), .txData(txData), .txValid(txValid), .txReady(txReady),
    .haltSetReq(haltSetReq), .haltClrReq(haltClrReq), .readProtect(readProtect),
    .haltStateBit(haltStateBit), .coreFetchEn(coreFetchEn),
    .onchipDebugReset(onchipDebugReset), .cmdAbort(cmdAbort), .errBreak(errBreak),
    .errFrame(errFrame), .errCollision(errCollision), .baudLocked(baudLocked),
    .bitPeriod(bitPeriod));
  sdl_host_model #(.HP(P)) host (.ref_clk(ref_clk), .wireLevel(wireLevel), .hostOe(hostOe));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Counts pulses, lock and release edges, and device pull-down runs.
  always @(posedge ref_clk) begin
    if (rxValid === 1'b1) begin
      nRx++;
      lastRx = rxData;
    end
    nFrame += (errFrame === 1'b1);
    nBreak += (errBreak === 1'b1);
    nColl += (errCollision === 1'b1);
    nAbort += (cmdAbort === 1'b1);
    nLock += (baudLocked === 1'b1 && !wasLock);
    nRel += (onchipDebugReset === 1'b0 && wasRst);
    wasLock = (baudLocked === 1'b1);
    wasRst = (onchipDebugReset === 1'b1);
    if (pinOe === 1'b1) begin
      oeRun++;
    end else if (oeRun > 0) begin
      lastRun = oeRun;
      nOeEnd++;
      oeRun = 0;
    end
  end
  task automatic results();
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic timeout(input string what);
    failures++;
    $display("MISMATCH %s expected event seen timeout", what);
    results();
  endtask
  task automatic wait_cnt(ref int cnt, input int base, input int lim, input string what);
    for (int t = 0; t < lim && cnt <= base; t++) @(posedge ref_clk);
    if (cnt <= base) timeout(what);
  endtask
  task automatic take_tx(input sdl_byte_t d);
    int t;
    t = 0;
    txData <= d;
    txValid <= 1'b1;
    do begin
      @(posedge ref_clk);
      t++;
    end while (txReady !== 1'b1 && t < 100);
    if (txReady !== 1'b1) timeout("txReady");
    txValid <= 1'b0;
  endtask
  task automatic t_reset();
    check("haltStateBit", 16'h0, haltStateBit);
    check("coreFetchEn", 16'h1, coreFetchEn);
    check("bitPeriod", 16'h8, bitPeriod);
    check("txReady", 16'h0, txReady);
    check("pinOe", 16'h0, pinOe);
    check("pinOut", 16'h0, pinOut);
    $display("test reset done");
  endtask
  task automatic t_sync();
    host.hold_low(4200);
    repeat (20) @(posedge ref_clk);
    b0 = nLock;
    host.send_byte(`SDL_SYNC_CHAR, 1'b1);
    wait_cnt(nLock, b0, 50, "baudLocked");
    check("bitPeriod", 16'(P), bitPeriod);
    repeat (5) @(posedge ref_clk);
    $display("test sync done");
  endtask
  task automatic t_rxtx();
    b0 = nRx;
    host.send_byte(8'ha5, 1'b1);
    wait_cnt(nRx, b0, 30, "rxValid");
    check("rxData", 16'ha5, lastRx);
    repeat (P) @(posedge ref_clk);
    take_tx(8'h3c);
    host.recv_byte(got, sb, lost);
    if (lost) timeout("txStart");
    check("txByte", 16'h3c, got);
    check("txStop", 16'h1, sb);
    repeat (2 * P) @(posedge ref_clk);
    $display("test rxtx done");
  endtask
  task automatic t_exec();
    b0 = nRx;
    cmdExpect <= 1'b1;
    host.send_byte(`SDL_CMD_EXEC, 1'b1);
    cmdExpect <= 1'b0;
    host.send_byte(8'h55, 1'b1);
    host.send_byte(8'h66, 1'b1);
    repeat (2 * P) @(posedge ref_clk);
    check("rxCount", 16'(b0 + 2), 16'(nRx));
    check("rxData", 16'h66, lastRx);
    haltSetReq <= 1'b1;
    @(posedge ref_clk);
    haltSetReq <= 1'b0;
    readProtect <= 1'b1;
    haltClrReq <= 1'b1;
    @(posedge ref_clk);
    haltClrReq <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("haltStateBit", 16'h1, haltStateBit);
    check("coreFetchEn", 16'h0, coreFetchEn);
    b0 = nRx;
    cmdExpect <= 1'b1;
    host.send_byte(`SDL_CMD_EXEC, 1'b1);
    cmdExpect <= 1'b0;
    host.send_byte(8'h44, 1'b1);
    repeat (2 * P) @(posedge ref_clk);
    check("rxCount", 16'(b0 + 1), 16'(nRx));
    readProtect <= 1'b0;
    b0 = nRx;
    cmdExpect <= 1'b1;
    host.send_byte(`SDL_CMD_EXEC, 1'b1);
    cmdExpect <= 1'b0;
    host.send_byte(8'h77, 1'b1);
    repeat (2 * P) @(posedge ref_clk);
    check("rxCount", 16'(b0 + 2), 16'(nRx));
    check("rxData", 16'h77, lastRx);
    haltClrReq <= 1'b1;
    @(posedge ref_clk);
    haltClrReq <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("haltStateBit", 16'h0, haltStateBit);
    check("coreFetchEn", 16'h1, coreFetchEn);
    haltSetReq <= 1'b1;
    @(posedge ref_clk);
    haltSetReq <= 1'b0;
    $display("test exec done");
  endtask
  task automatic t_error(input int kind);
    b0 = nAbort;
    if (kind == 0) begin
      host.send_byte(8'hff, 1'b0);
    end else if (kind == 1) begin
      host.hold_low(12 * P);
    end else begin
      take_tx(8'hff);
      repeat (2 * P + 2) @(posedge ref_clk);
      host.hold_low(P);
    end
    repeat (2) @(posedge ref_clk);
    check("errFrame", 16'h1, 16'(nFrame));
    check("errBreak", 16'(kind >= 1), 16'(nBreak));
    check("errCollision", 16'(kind == 2), 16'(nColl));
    check("onchipDebugReset", 16'(kind == 1), onchipDebugReset);
    check("cmdAbort", 16'(b0 + 1), 16'(nAbort));
    b1 = nOeEnd;
    b0 = nRel;
    wait_cnt(nOeEnd, b1, 600, "returned break");
    check("breakLen", 16'(`SDL_ERR_BREAK_BITS * P), 16'(lastRun));
    if (kind == 1) wait_cnt(nRel, b0, 20, "onchipDebugReset");
    repeat (4) @(posedge ref_clk);
    check("onchipDebugReset", 16'h0, onchipDebugReset);
    check("baudLocked", 16'h0, baudLocked);
    check("haltStateBit", 16'h1, haltStateBit);
    $display("test error %0d done", kind);
  endtask
  initial begin
    {cmdExpect, txValid, haltSetReq, haltClrReq, readProtect} = '0;
    txData = 8'h00;
    rst_n = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_sync();
    t_rxtx();
    t_exec();
    for (int k = 0; k < 3; k++) begin
      t_error(k);
      t_sync();
    end
    results();
  end
endmodule // sdl_link_top_test
